/* event_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser per bit; events from other domains must be held
// for at least two clocks so a level is seen
module event_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    if (WIDTH < 1) begin : g_width_check
        $error("event_sync WIDTH must be positive");
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    assign sync_out = stage2;
endmodule // event_sync
`default_nettype wire

/* exception_notify_engine.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fault_defines.svh"

module exception_notify_engine
    import fault_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire fault_pkg::fault_events_t fault_events,
    input wire fault_pkg::reg_req_t reg_req,
    output logic [7:0] rdata,
    output logic fault_notify_line,
    output logic irq
);
    logic [7:0] fault_code_register;
    logic [7:0] legacy_fault_mask;
    logic [7:0] new_fault_flags;
    logic [7:0] new_fault_mask;
    logic [7:0] irq_mask;
    logic legacy_mode;
    logic fault_hit;
    logic [7:0] hit_code;
    logic [7:0] hit_flags;
    logic [7:0] next_flags;
    logic [7:0] next_new_mask;
    logic [7:0] next_irq_mask;
    logic next_line;
    logic code_read;
    logic [7:0] synced_bits;
    fault_events_t synced_events;

    event_sync #(
        .WIDTH(`FLAG_COUNT)
    ) u_sync (
        .clock(clock),
        .nrst(nrst),
        .async_in(fault_events),
        .sync_out(synced_bits)
    );

    // Level-to-pulse: an event counts once on its rising edge
    logic [7:0] prev_bits;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prev_bits <= `RESET_BYTE;
        end else begin
            prev_bits <= synced_bits;
        end
    end
    assign synced_events = fault_events_t'(synced_bits & ~prev_bits);

    fault_encoder u_enc (
        .events(synced_events),
        .hit(fault_hit),
        .code(hit_code),
        .flag_set(hit_flags)
    );

    assign legacy_mode = (legacy_fault_mask != `RESET_BYTE);
    assign code_read = reg_req.rd && (reg_req.addr == `ADDR_CODE);

    // Code register holds the latest fault regardless of mask
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fault_code_register <= `RESET_BYTE;
        end else if (fault_hit) begin
            fault_code_register <= hit_code;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            legacy_fault_mask <= `RESET_BYTE;
        end else if (reg_req.wr && reg_req.addr == `ADDR_LEGACY_MASK) begin
            legacy_fault_mask <= reg_req.wdata;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_mask <= `RESET_BYTE;
        end else if (reg_req.wr && reg_req.addr == `ADDR_LINE_STATE) begin
            irq_mask <= reg_req.wdata;
        end
    end

    // Write-one-to-clear; a fault arriving in the same cycle wins
    always_comb begin
        next_flags = new_fault_flags;
        if (reg_req.wr && reg_req.addr == `ADDR_FLAGS) begin
            next_flags = next_flags & ~reg_req.wdata;
        end
        next_flags = next_flags | hit_flags;
    end

    always_comb begin
        next_new_mask = new_fault_mask;
        if (reg_req.wr && reg_req.addr == `ADDR_NEW_MASK) begin
            next_new_mask = reg_req.wdata;
        end
    end

    // Mask as written this edge, so irq follows a mask write with no extra lag
    always_comb begin
        next_irq_mask = irq_mask;
        if (reg_req.wr && reg_req.addr == `ADDR_LINE_STATE) begin
            next_irq_mask = reg_req.wdata;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            new_fault_flags <= `RESET_BYTE;
            new_fault_mask <= `RESET_BYTE;
        end else begin
            new_fault_flags <= next_flags;
            new_fault_mask <= next_new_mask;
        end
    end

    // Legacy line: a masked fault sets it, a code read clears it; a masked fault
    // in the same cycle as the read keeps it set so that fault is not lost.
    // The mode is judged on the mask as it stood before this cycle's write.
    always_comb begin
        if (legacy_mode) begin
            next_line = fault_notify_line;
            if (code_read) begin
                next_line = 1'b0;
            end
            if (fault_hit && ((hit_code & legacy_fault_mask) != `RESET_BYTE)) begin
                next_line = 1'b1;
            end
        end else begin
            next_line = ((next_flags & next_new_mask) != `RESET_BYTE);
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fault_notify_line <= 1'b0;
        end else begin
            fault_notify_line <= next_line;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= ((next_flags & next_irq_mask) != `RESET_BYTE);
        end
    end

    // Read data appear the cycle after the strobe
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata <= `RESET_BYTE;
        end else if (reg_req.rd) begin
            unique case (reg_req.addr)
                `ADDR_CODE: rdata <= fault_code_register;
                `ADDR_LEGACY_MASK: rdata <= legacy_fault_mask;
                `ADDR_FLAGS: rdata <= new_fault_flags;
                `ADDR_NEW_MASK: rdata <= new_fault_mask;
                `ADDR_LINE_STATE: rdata <= {irq_mask[7:1], fault_notify_line};
                default: rdata <= `RESET_BYTE;
            endcase
        end else begin
            rdata <= `RESET_BYTE;
        end
    end

    property p_legacy_clear;
        @(posedge clock) disable iff (!nrst)
        (legacy_mode && code_read && !fault_hit) |=> !fault_notify_line;
    endproperty
    a_legacy_clear: assert property (p_legacy_clear)
        else $error("line not cleared by code read");

    property p_legacy_set;
        @(posedge clock) disable iff (!nrst)
        (legacy_mode && fault_hit && ((hit_code & legacy_fault_mask) != `RESET_BYTE))
            |=> fault_notify_line;
    endproperty
    a_legacy_set: assert property (p_legacy_set)
        else $error("masked fault did not raise line");

    property p_legacy_hold;
        @(posedge clock) disable iff (!nrst)
        (legacy_mode && !code_read && !fault_hit) |=> $stable(fault_notify_line);
    endproperty
    a_legacy_hold: assert property (p_legacy_hold)
        else $error("legacy line changed spuriously");

    property p_code_store;
        @(posedge clock) disable iff (!nrst)
        fault_hit |=> (fault_code_register == $past(hit_code));
    endproperty
    a_code_store: assert property (p_code_store) else $error("code not stored");

    property p_flag_set;
        @(posedge clock) disable iff (!nrst)
        fault_hit |=> ((new_fault_flags & $past(hit_flags)) == $past(hit_flags));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set with code");

    property p_ext_line;
        @(posedge clock) disable iff (!nrst)
        (!legacy_mode && !fault_hit && reg_req.wr && (reg_req.addr == `ADDR_FLAGS)
            && ((new_fault_flags & ~reg_req.wdata & new_fault_mask) == `RESET_BYTE))
            |=> !fault_notify_line;
    endproperty
    a_ext_line: assert property (p_ext_line)
        else $error("line kept after last enabled flag cleared");

    property p_ext_keep;
        @(posedge clock) disable iff (!nrst)
        (!legacy_mode && reg_req.wr && (reg_req.addr == `ADDR_FLAGS)
            && ((new_fault_flags & ~reg_req.wdata & new_fault_mask) != `RESET_BYTE))
            |=> fault_notify_line;
    endproperty
    a_ext_keep: assert property (p_ext_keep)
        else $error("line dropped with enabled flag left");

    property p_ext_mask_write;
        @(posedge clock) disable iff (!nrst)
        (!legacy_mode && reg_req.wr && (reg_req.addr == `ADDR_NEW_MASK)
            && ((new_fault_flags & reg_req.wdata) != `RESET_BYTE))
            |=> fault_notify_line;
    endproperty
    a_ext_mask_write: assert property (p_ext_mask_write)
        else $error("mask write did not raise line");

    property p_legacy_mask_write;
        @(posedge clock) disable iff (!nrst)
        (legacy_mode && !fault_hit && reg_req.wr && (reg_req.addr == `ADDR_LEGACY_MASK))
            |=> $stable(fault_notify_line);
    endproperty
    a_legacy_mask_write: assert property (p_legacy_mask_write)
        else $error("legacy mask write moved line");

    property p_legacy_unmasked;
        @(posedge clock) disable iff (!nrst)
        (legacy_mode && fault_hit && !code_read
            && ((hit_code & legacy_fault_mask) == `RESET_BYTE))
            |=> $stable(fault_notify_line);
    endproperty
    a_legacy_unmasked: assert property (p_legacy_unmasked)
        else $error("unmasked fault moved line");

    property p_ext_follow;
        @(posedge clock) disable iff (!nrst)
        !legacy_mode
            |=> (fault_notify_line == ((new_fault_flags & new_fault_mask) != `RESET_BYTE));
    endproperty
    a_ext_follow: assert property (p_ext_follow) else $error("extended line mismatch");

    property p_mirror;
        @(posedge clock) disable iff (!nrst)
        (reg_req.rd && reg_req.addr == `ADDR_LINE_STATE) |=> (rdata[0] == $past(fault_notify_line));
    endproperty
    a_mirror: assert property (p_mirror) else $error("line state not mirrored");

    // One sticky check per flag bit
    for (genvar b = 0; b < `FLAG_COUNT; b++) begin : g_sticky
        property p_flag_sticky;
            @(posedge clock) disable iff (!nrst)
            (new_fault_flags[b] && !(reg_req.wr && reg_req.addr == `ADDR_FLAGS))
                |=> new_fault_flags[b];
        endproperty
        a_flag_sticky: assert property (p_flag_sticky)
            else $error("flag dropped without clear");
    end

    property p_code_value;
        @(posedge clock) disable iff (!nrst)
        (fault_hit && synced_events.frame_type_error) |=> (fault_code_register == `CODE_FRAME_ERR);
    endproperty
    a_code_value: assert property (p_code_value) else $error("wrong frame type code");

    property p_code_hold;
        @(posedge clock) disable iff (!nrst)
        !fault_hit
            |=> $stable(fault_code_register);
    endproperty
    a_code_hold: assert property (p_code_hold)
        else $error("code changed without a fault");

    property p_code_read_data;
        @(posedge clock) disable iff (!nrst)
        code_read
            |=> (rdata == $past(fault_code_register));
    endproperty
    a_code_read_data: assert property (p_code_read_data)
        else $error("code read returned wrong data");

    property p_rdata_idle;
        @(posedge clock) disable iff (!nrst)
        !reg_req.rd
            |=> (rdata == `RESET_BYTE);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not idle");

    property p_unmapped;
        @(posedge clock) disable iff (!nrst)
        (reg_req.rd && (reg_req.addr > `ADDR_LINE_STATE))
            |=> (rdata == `RESET_BYTE);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_irq_level;
        @(posedge clock) disable iff (!nrst)
        irq == ((new_fault_flags & irq_mask) != `RESET_BYTE);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("irq does not follow masked flags");

    property p_mask_readback;
        @(posedge clock) disable iff (!nrst)
        (reg_req.rd && (reg_req.addr == `ADDR_LEGACY_MASK))
            |=> (rdata == $past(legacy_fault_mask));
    endproperty
    a_mask_readback: assert property (p_mask_readback)
        else $error("legacy mask readback wrong");

    property p_flag_clear;
        @(posedge clock) disable iff (!nrst)
        (reg_req.wr && (reg_req.addr == `ADDR_FLAGS) && !fault_hit)
            |=> ((new_fault_flags & $past(reg_req.wdata)) == `RESET_BYTE);
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag not cleared by write");
endmodule // exception_notify_engine
`default_nettype wire

/* exception_notify_engine_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fault_defines.svh"

`define CHECK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end

module exception_notify_engine_tb;
    import fault_pkg::*;
    logic clock;
    logic nrst;
    fault_events_t ev;
    reg_req_t req;
    logic [7:0] rdata;
    logic fault_notify_line;
    logic irq;
    logic host_line;
    logic host_irq;
    logic [7:0] d;
    logic [7:0] codes [8] = '{8'h08, 8'h09, 8'h13, 8'h20, 8'h40, 8'h42, 8'h43, 8'h44};
    int fail_count = 0;
    int num_checks = 0;

    exception_notify_engine u_exception_notify_engine (
        .clock(clock), .nrst(nrst), .fault_events(ev), .reg_req(req),
        .rdata(rdata), .fault_notify_line(fault_notify_line), .irq(irq)
    );
    fault_host_model u_fault_host_model (
        .clock(clock), .nrst(nrst), .fault_notify_line(fault_notify_line), .irq(irq),
        .host_line(host_line), .host_irq(host_irq)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req.wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clock);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    // Held three clocks so the synchroniser sees a level; update lands three edges later
    task automatic fire_bits(input logic [7:0] m);
        @(posedge clock);
        ev <= fault_events_t'(m);
        repeat (3) @(posedge clock);
        ev <= '0;
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic fire(input int i);
        fire_bits(8'h80 >> i);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        results();
    end

    initial begin
        nrst = 1'b0;
        ev = '0;
        req = '0;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        for (int a = 0; a < 5; a++) begin
            rd(a[3:0], d);
            `CHECK(d, 8'h00)
        end
        rd(4'hF, d);
        `CHECK(d, 8'h00)
        wr(`ADDR_LEGACY_MASK, 8'h60);
        `CHECK(fault_notify_line, 1'b0)
        for (int i = 0; i < 8; i++) begin
            fire(i);
            rd(`ADDR_LINE_STATE, d);
            `CHECK(d, {7'h00, |(codes[i] & 8'h60)})
            `CHECK(host_line, |(codes[i] & 8'h60))
            rd(`ADDR_CODE, d);
            `CHECK(d, codes[i])
            `CHECK(fault_notify_line, 1'b0)
            rd(`ADDR_FLAGS, d);
            `CHECK(d, 8'((9'h1 << (i + 1)) - 9'h1))
        end
        fire(4);
        fire(0);
        `CHECK(fault_notify_line, 1'b1)
        wr(`ADDR_LEGACY_MASK, 8'h08);
        `CHECK(fault_notify_line, 1'b1)
        rd(`ADDR_LEGACY_MASK, d);
        `CHECK(d, 8'h08)
        `CHECK(fault_notify_line, 1'b1)
        rd(`ADDR_CODE, d);
        `CHECK(d, `CODE_RX_OVF)
        `CHECK(fault_notify_line, 1'b0)
        wr(`ADDR_LEGACY_MASK, 8'h00);
        `CHECK(fault_notify_line, 1'b0)
        wr(`ADDR_NEW_MASK, 8'h05);
        `CHECK(fault_notify_line, 1'b1)
        wr(`ADDR_FLAGS, 8'h01);
        `CHECK(fault_notify_line, 1'b1)
        wr(`ADDR_FLAGS, 8'h04);
        `CHECK(fault_notify_line, 1'b0)
        rd(`ADDR_FLAGS, d);
        `CHECK(d, 8'hFA)
        wr(`ADDR_LINE_STATE, 8'h02);
        `CHECK(irq, 1'b1)
        rd(`ADDR_LINE_STATE, d);
        `CHECK(d, 8'h02)
        `CHECK(host_irq, 1'b1)
        wr(`ADDR_FLAGS, 8'h02);
        `CHECK(irq, 1'b0)
        @(posedge clock);
        #1;
        `CHECK(host_irq, 1'b0)
        fire(2);
        `CHECK(fault_notify_line, 1'b1)
        rd(`ADDR_CODE, d);
        `CHECK(fault_notify_line, 1'b1)
        @(posedge clock);
        nrst <= 1'b0;
        @(posedge clock);
        #1;
        `CHECK(fault_notify_line, 1'b0)
        `CHECK(rdata, 8'h00)
        @(posedge clock);
        nrst <= 1'b1;
        rd(`ADDR_FLAGS, d);
        `CHECK(d, 8'h00)
        rd(`ADDR_CODE, d);
        `CHECK(d, 8'h00)
        rd(`ADDR_NEW_MASK, d);
        `CHECK(d, 8'h00)
        fire_bits(8'h81);
        rd(`ADDR_CODE, d);
        `CHECK(d, `CODE_FRAME_ERR)
        rd(`ADDR_FLAGS, d);
        `CHECK(d, 8'h81)
        `CHECK(fault_notify_line, 1'b0)
        results();
    end
endmodule // exception_notify_engine_tb

`default_nettype wire

/* fault_defines.svh */
`ifndef FAULT_DEFINES_SVH
`define FAULT_DEFINES_SVH

// Register addresses
`define ADDR_CODE 4'h0
`define ADDR_LEGACY_MASK 4'h1
`define ADDR_FLAGS 4'h2
`define ADDR_NEW_MASK 4'h3
`define ADDR_LINE_STATE 4'h4

// Fault codes
`define CODE_RX_OVF 8'h08
`define CODE_TX_OVF 8'h09
`define CODE_WR_FAIL 8'h13
`define CODE_NO_ACK 8'h20
`define CODE_PAY_CRC 8'h40
`define CODE_HDR_CRC 8'h42
`define CODE_SEQ_ERR 8'h43
`define CODE_FRAME_ERR 8'h44

// Flag bit positions
`define FLAG_RX_OVF 0
`define FLAG_TX_OVF 1
`define FLAG_WR_FAIL 2
`define FLAG_NO_ACK 3
`define FLAG_PAY_CRC 4
`define FLAG_HDR_CRC 5
`define FLAG_SEQ_ERR 6
`define FLAG_FRAME_ERR 7
`define FLAG_COUNT 8

`define RESET_BYTE 8'h00

`endif

/* fault_encoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fault_defines.svh"

// Picks one code per cycle; later entries in the list win when events coincide
module fault_encoder
    import fault_pkg::*;
(
    input wire fault_pkg::fault_events_t events,
    output logic hit,
    output logic [7:0] code,
    output logic [7:0] flag_set
);
    always_comb begin
        hit = 1'b0;
        code = `RESET_BYTE;
        flag_set = `RESET_BYTE;
        if (events.rx_uart_overflow) begin
            hit = 1'b1;
            code = `CODE_RX_OVF;
            flag_set[`FLAG_RX_OVF] = 1'b1;
        end
        if (events.tx_uart_overflow) begin
            hit = 1'b1;
            code = `CODE_TX_OVF;
            flag_set[`FLAG_TX_OVF] = 1'b1;
        end
        if (events.register_write_failure) begin
            hit = 1'b1;
            code = `CODE_WR_FAIL;
            flag_set[`FLAG_WR_FAIL] = 1'b1;
        end
        if (events.missing_acknowledge) begin
            hit = 1'b1;
            code = `CODE_NO_ACK;
            flag_set[`FLAG_NO_ACK] = 1'b1;
        end
        if (events.payload_crc_error) begin
            hit = 1'b1;
            code = `CODE_PAY_CRC;
            flag_set[`FLAG_PAY_CRC] = 1'b1;
        end
        if (events.header_crc_error) begin
            hit = 1'b1;
            code = `CODE_HDR_CRC;
            flag_set[`FLAG_HDR_CRC] = 1'b1;
        end
        if (events.ack_sequence_error) begin
            hit = 1'b1;
            code = `CODE_SEQ_ERR;
            flag_set[`FLAG_SEQ_ERR] = 1'b1;
        end
        if (events.frame_type_error) begin
            hit = 1'b1;
            code = `CODE_FRAME_ERR;
            flag_set[`FLAG_FRAME_ERR] = 1'b1;
        end
    end
endmodule // fault_encoder
`default_nettype wire

/* fault_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Host side: it watches the fault pin as a plain level and samples it once a clock
// It never drives the block; register traffic is left to the bench tasks
module fault_host_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic fault_notify_line,
    input wire logic irq,
    output logic host_line,
    output logic host_irq
);
    // Sampling the pin instead of polling the registers, on every clock whatever the traffic
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            host_line <= 1'b0;
            host_irq <= 1'b0;
        end else begin
            host_line <= fault_notify_line;
            host_irq <= irq;
        end
    end
endmodule // fault_host_model

`default_nettype wire

/* fault_pkg.sv */
`default_nettype none
package fault_pkg;
    typedef struct packed {
        logic rx_uart_overflow;
        logic tx_uart_overflow;
        logic register_write_failure;
        logic missing_acknowledge;
        logic payload_crc_error;
        logic header_crc_error;
        logic ack_sequence_error;
        logic frame_type_error;
    } fault_events_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage
`default_nettype wire
